// file: design/timer2_params.svh
// register indices, field positions, reset values and timing counts of the capture/reload timer
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define TMR_IDX_CTRL       8'hc8
`define TMR_IDX_RCAP_LO    8'hca
`define TMR_IDX_RCAP_HI    8'hcb
`define TMR_IDX_CNT_LO     8'hcc
`define TMR_IDX_CNT_HI     8'hcd
`define TMR_IDX_IRQ_STAT   8'hd0
`define TMR_IDX_IRQ_MASK   8'hd1

// control register field positions
`define TMR_CTRL_OVF_BIT   7
`define TMR_CTRL_EXT_BIT   6
`define TMR_CTRL_RXS_BIT   5
`define TMR_CTRL_TXS_BIT   4
`define TMR_CTRL_TEN_BIT   3
`define TMR_CTRL_RUN_BIT   2
`define TMR_CTRL_CNT_BIT   1
`define TMR_CTRL_CAP_BIT   0

// interrupt status and mask field positions
`define TMR_IRQ_OVF_BIT    0
`define TMR_IRQ_EXT_BIT    1

// reset values
`define TMR_CTRL_RST       8'h00
`define TMR_WORD_RST       16'h0000
`define TMR_IRQ_RST        2'h0

// terminal count of the 16-bit counter
`define TMR_CNT_MAX        16'hffff

// core-clock ticks per timer increment in timer function
`define TMR_TICK_DIV       1

`endif

// file: design/timer2_pkg.sv
// types shared by the capture/reload timer
package timer2_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic ovf;
    logic ext;
    logic rx_sel;
    logic tx_sel;
    logic trig_en;
    logic run;
    logic cnt_sel;
    logic cap_sel;
  } ctrl_type;

  // 16-bit value held as two software-visible bytes
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } word_type;

  // interrupt status / mask layout
  typedef struct packed {
    logic ext;
    logic ovf;
  } irq_type;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_RELOAD,
    MODE_CAPTURE,
    MODE_BAUD
  } mode_type;

endpackage

// file: design/timer2_capture_reload.sv
// 16-bit timer/counter with autoreload, capture and baud tick generation, wishbone slave
`timescale 1ns/100ps
`default_nettype none
`include "timer2_params.svh"

module timer2_capture_reload
  import timer2_pkg::*;
#(
  parameter int TICK_DIV = `TMR_TICK_DIV
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // external pins
  input  wire logic        count_input_pin,
  input  wire logic        trigger_input_pin,
  // serial port clocks
  output var  logic        rx_baud_tick,
  output var  logic        tx_baud_tick,
  // interrupt
  output var  logic        irq
);

  ctrl_type    ctrl_r;
  word_type    count_r;
  word_type    rcap_r;
  irq_type     stat_r;
  irq_type     mask_r;
  logic [15:0] presc_r;
  logic [2:0]  cnt_sync_r;
  logic [2:0]  trig_sync_r;

  mode_type    mode;
  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic        wr_ctrl;
  logic        cnt_fall;
  logic        trig_fall;
  logic        core_tick;
  logic        tick;
  logic        ovf_evt;
  logic        trig_evt;
  logic        trig_act;
  logic        do_reload;
  logic        do_capture;
  logic        ovf_set;
  ctrl_type    wctrl;
  irq_type     wirq;
  irq_type     irq_set;

  // bus decode; a request is taken once, in the cycle before ack
  assign idx     = wb_adr_i[9:2];
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl = wr & (idx == `TMR_IDX_CTRL);
  assign wctrl   = ctrl_type'(wb_dat_i[7:0]);
  assign wirq    = irq_type'(wb_dat_i[1:0]);

  // mode decode; serial selects override the capture select
  always_comb begin
    if (!ctrl_r.run) begin
      mode = MODE_OFF;
    end else if (ctrl_r.rx_sel | ctrl_r.tx_sel) begin
      mode = MODE_BAUD;
    end else if (ctrl_r.cap_sel) begin
      mode = MODE_CAPTURE;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  // pin synchronisers; the third stage holds the previous sample for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_sync_r  <= 3'h7;
      trig_sync_r <= 3'h7;
    end else begin
      cnt_sync_r  <= {cnt_sync_r[1:0], count_input_pin};
      trig_sync_r <= {trig_sync_r[1:0], trigger_input_pin};
    end
  end

  // one falling edge per sample: previous high, current low
  assign cnt_fall  = cnt_sync_r[2] & ~cnt_sync_r[1];
  assign trig_fall = trig_sync_r[2] & ~trig_sync_r[1];

  // core tick prescaler, only advances while running so a restart is clean
  always_ff @(posedge sys_clk) begin
    if (rst || !ctrl_r.run || core_tick) begin
      presc_r <= 16'h0000;
    end else begin
      presc_r <= 16'(presc_r + 16'h0001);
    end
  end

  assign core_tick = (presc_r == 16'(TICK_DIV - 1));

  // count source and events
  assign tick     = ctrl_r.run & (ctrl_r.cnt_sel ? cnt_fall : core_tick);
  assign ovf_evt  = tick & (count_r == word_type'(`TMR_CNT_MAX));
  assign trig_evt = trig_fall & ctrl_r.trig_en & (mode != MODE_OFF);
  // trigger edges never move the count while the timer clocks the serial port
  assign trig_act = trig_evt & (mode != MODE_BAUD);
  assign do_reload  = (ovf_evt & ((mode == MODE_RELOAD) | (mode == MODE_BAUD)))
                    | (trig_act & (mode == MODE_RELOAD));
  assign do_capture = trig_act & (mode == MODE_CAPTURE);
  assign ovf_set    = ovf_evt & (mode != MODE_BAUD);

  // counter bytes; a software write wins over counting in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= word_type'(`TMR_WORD_RST);
    end else if (wr && idx == `TMR_IDX_CNT_LO) begin
      count_r.lo <= wb_dat_i[7:0];
    end else if (wr && idx == `TMR_IDX_CNT_HI) begin
      count_r.hi <= wb_dat_i[7:0];
    end else if (do_reload) begin
      count_r <= rcap_r;
    end else if (tick) begin
      count_r <= word_type'(16'(count_r + 16'h0001));
    end
  end

  // reload/capture pair; a capture is never lost to a coincident write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rcap_r <= word_type'(`TMR_WORD_RST);
    end else if (do_capture) begin
      rcap_r.lo <= count_r.lo;
      rcap_r.hi <= count_r.hi;
    end else if (wr && idx == `TMR_IDX_RCAP_LO) begin
      rcap_r.lo <= wb_dat_i[7:0];
    end else if (wr && idx == `TMR_IDX_RCAP_HI) begin
      rcap_r.hi <= wb_dat_i[7:0];
    end
  end

  // control register; hardware setting of a flag wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= ctrl_type'(`TMR_CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wctrl;
      end
      if (ovf_set) begin
        ctrl_r.ovf <= 1'b1;
      end
      if (trig_evt) begin
        ctrl_r.ext <= 1'b1;
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign irq_set.ovf = ovf_set;
  assign irq_set.ext = trig_evt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_r <= irq_type'(`TMR_IRQ_RST);
    end else if (wr && idx == `TMR_IDX_IRQ_STAT) begin
      stat_r <= (stat_r & ~wirq) | irq_set;
    end else begin
      stat_r <= stat_r | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_r <= irq_type'(`TMR_IRQ_RST);
    end else if (wr && idx == `TMR_IDX_IRQ_MASK) begin
      mask_r <= wirq;
    end
  end

  // interrupt level, registered so the pin is glitch free
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & mask_r);
    end
  end

  // serial port clocks: one pulse per overflow in baud mode, on each clock whose select bit is set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
    end else begin
      rx_baud_tick <= ovf_evt & (mode == MODE_BAUD) & ctrl_r.rx_sel;
      tx_baud_tick <= ovf_evt & (mode == MODE_BAUD) & ctrl_r.tx_sel;
    end
  end

  // bus answer: ack one cycle after the request, read data with it; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        unique case (idx)
          `TMR_IDX_CTRL:     wb_dat_o[7:0] <= ctrl_r;
          `TMR_IDX_RCAP_LO:  wb_dat_o[7:0] <= rcap_r.lo;
          `TMR_IDX_RCAP_HI:  wb_dat_o[7:0] <= rcap_r.hi;
          `TMR_IDX_CNT_LO:   wb_dat_o[7:0] <= count_r.lo;
          `TMR_IDX_CNT_HI:   wb_dat_o[7:0] <= count_r.hi;
          `TMR_IDX_IRQ_STAT: wb_dat_o[1:0] <= stat_r;
          `TMR_IDX_IRQ_MASK: wb_dat_o[1:0] <= mask_r;
          default:           wb_dat_o      <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---- assertions ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_edge_enabled;
    trig_fall && ctrl_r.trig_en && ctrl_r.run;
  endsequence

  sequence s_ext_flag_up;
    ctrl_r.ext && stat_r.ext;
  endsequence

  property p_ovf_flag;
    ovf_evt && (mode != MODE_BAUD) |=> ctrl_r.ovf && stat_r.ovf;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

  property p_ext_flag;
    s_edge_enabled |=> s_ext_flag_up;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("trigger edge did not set flag");

  property p_rx_tick;
    ovf_evt && (mode == MODE_BAUD) |=> rx_baud_tick == $past(ctrl_r.rx_sel) ##1 !rx_baud_tick || $past(ovf_evt);
  endproperty
  a_rx_tick: assert property (p_rx_tick) else $error("receive tick wrong");

  property p_tx_tick;
    !(ovf_evt && (mode == MODE_BAUD) && ctrl_r.tx_sel) |=> !tx_baud_tick;
  endproperty
  a_tx_tick: assert property (p_tx_tick) else $error("transmit tick without baud overflow");

  property p_trig_ignored;
    trig_fall && !ctrl_r.trig_en && !ctrl_r.ext && !wr_ctrl |=> !ctrl_r.ext;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("disabled trigger edge acted");

  property p_stopped;
    (mode == MODE_OFF) && !wr |=> $stable(count_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");

  property p_reload;
    do_reload && !wr |=> count_r == $past(rcap_r);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");

  property p_capture;
    s_edge_enabled ##0 (mode == MODE_CAPTURE) |=> rcap_r == $past(count_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_baud_no_ovf;
    (mode == MODE_BAUD) && !ctrl_r.ovf && !wr_ctrl |=> !ctrl_r.ovf;
  endproperty
  a_baud_no_ovf: assert property (p_baud_no_ovf) else $error("overflow flag set in baud mode");

  property p_count_up;
    tick && !ovf_evt && !wr && !trig_act |=> count_r == word_type'(16'($past(count_r) + 16'h0001));
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not advance");

  property p_irq_level;
    |(stat_r & mask_r) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  property p_ack_once;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

endmodule
`default_nettype wire

// file: testbench/timer2_far_side.sv
// far-side model: count and trigger pins, and the serial port's tick timing
`timescale 1ns/100ps
`default_nettype none
module timer2_far_side (
  // clock
  input  wire logic sys_clk,
  // serial clocks from the timer
  input  wire logic rx_baud_tick,
  input  wire logic tx_baud_tick,
  // pins, idle high as if pulled up
  output var  logic count_pin,
  output var  logic trig_pin
);
  int cyc_n = 0;
  int tx_q[$];
  int rx_q[$];

  initial begin
    count_pin = 1'b1;
    trig_pin  = 1'b1;
  end

  // stamp each tick so the bench can measure the period
  always @(posedge sys_clk) begin
    cyc_n++;
    if (tx_baud_tick === 1'b1) tx_q.push_back(cyc_n);
    if (rx_baud_tick === 1'b1) rx_q.push_back(cyc_n);
  end

  // each level held three cycles so the two-flop sampler never misses one
  task automatic pulse(input bit trig, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (trig) trig_pin <= 1'b0;
      else count_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
      trig_pin  <= 1'b1;
      count_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/timer2_capture_reload_tb_top.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module timer2_capture_reload_tb_top
  import timer2_pkg::*;
;
  logic        sys_clk, rst, cyc, stb, we, cnt_pin, trg_pin, rxt, txt, irq, ack;
  logic [9:0]  adr;
  logic [31:0] dat_w, dat_r;
  logic [7:0]  q, r;
  logic [7:0]  regs[7] = '{8'hc8, 8'hd0, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd1};
  int          fails = 0;
  int          check_count = 0;
  int          seed = 31385;
  int          mdl[int];
  int          tq[$], oq[$];

  timer2_capture_reload #(.TICK_DIV(1)) dut (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .count_input_pin(cnt_pin), .trigger_input_pin(trg_pin),
    .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq(irq));

  timer2_far_side far (
    .sys_clk(sys_clk), .rx_baud_tick(rxt), .tx_baud_tick(txt),
    .count_pin(cnt_pin), .trig_pin(trg_pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // one classic cycle; held until ack is sampled, read data taken there
  task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {i, 2'b00};
    dat_w <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(i, 1'b1, d);
    mdl[i] = d;
  endtask

  task automatic rd(input logic [7:0] i);
    bus(i, 1'b0, 8'h00);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs far fewer cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    finish_test();
  end

  initial begin
    rst   = 1'b1;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 10'h000;
    dat_w = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (regs[k]) begin
      rd(regs[k]);
      `CHK(q, 8'h00)
    end
    // random readback; an unmapped place reads zero
    for (int k = 2; k < 7; k++) begin
      wr(regs[k], 8'($random(seed)));
      rd(regs[k]);
      // the mask register only holds its two defined bits
      `CHK(q, 8'(mdl[regs[k]]) & ((regs[k] == 8'hd1) ? 8'h03 : 8'hff))
    end
    wr(8'h10, 8'hff);
    rd(8'h10);
    `CHK(q, 8'h00)
    // rollover reloads from the pair
    r = 8'h10 + 8'($random(seed) & 'h3f);
    wr(8'hcc, 8'hf8);
    wr(8'hcd, 8'hff);
    wr(8'hca, 8'h00);
    wr(8'hcb, r);
    wr(8'hc8, 8'h04);
    repeat (30) @(posedge sys_clk);
    rd(8'hc8);
    `CHK(q, 8'h84)
    rd(8'hd0);
    `CHK(q, 8'h01)
    wr(8'hc8, 8'h00);
    rd(8'hcd);
    `CHK(q, r)
    wr(8'hd0, 8'h03);
    rd(8'hd0);
    `CHK(q, 8'h00)
    // capture, then the interrupt masked, unmasked and cleared
    wr(8'hd1, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h55);
    wr(8'hc8, 8'h0d);
    far.pulse(1'b1, 1);
    rd(8'hcb);
    `CHK(q, 8'h55)
    rd(8'hc8);
    `CHK(q, 8'h4d)
    `CHK(irq, 1'b0)
    wr(8'hd1, 8'h02);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wr(8'hd0, 8'h02);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    // trigger disabled: no capture, no flag
    wr(8'hc8, 8'h00);
    wr(8'hcd, 8'h33);
    wr(8'hc8, 8'h05);
    far.pulse(1'b1, 1);
    rd(8'hcb);
    `CHK(q, 8'h55)
    rd(8'hc8);
    `CHK(q, 8'h05)
    // capture mode runs free: it wraps to zero instead of reloading, and flags the overflow
    wr(8'hc8, 8'h00);
    wr(8'hd0, 8'h03);
    wr(8'hd1, 8'h01);
    wr(8'hcc, 8'hf8);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h05);
    repeat (30) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wr(8'hc8, 8'h00);
    rd(8'hcd);
    `CHK(q, 8'h00)
    // trigger edge reloads in reload mode
    r = 8'h10 + 8'($random(seed) & 'h3f);
    wr(8'hc8, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hcb, r);
    wr(8'hc8, 8'h0c);
    far.pulse(1'b1, 1);
    rd(8'hc8);
    `CHK(q, 8'h4c)
    wr(8'hc8, 8'h00);
    rd(8'hcd);
    `CHK(q, r)
    // counting pin edges, then holding while stopped
    wr(8'hcc, 8'h10);
    wr(8'hc8, 8'h06);
    far.pulse(1'b0, 5);
    wr(8'hc8, 8'h00);
    rd(8'hcc);
    `CHK(q, 8'h15)
    repeat (20) @(posedge sys_clk);
    rd(8'hcc);
    `CHK(q, 8'h15)
    // baud mode: transmit then receive select, period from the reload pair
    for (int s = 0; s < 2; s++) begin
      wr(8'hc8, 8'h00);
      wr(8'hcc, 8'hf0);
      wr(8'hcd, 8'hff);
      wr(8'hca, 8'hf0);
      wr(8'hcb, 8'hff);
      wr(8'hd0, 8'h03);
      far.tx_q.delete();
      far.rx_q.delete();
      wr(8'hc8, s ? 8'h2d : 8'h1d);
      repeat (100) @(posedge sys_clk);
      far.pulse(1'b1, 1);
      rd(8'hc8);
      `CHK(q, s ? 8'h6d : 8'h5d)
      rd(8'hd0);
      `CHK(q, 8'h02)
      if (s) begin
        tq = far.rx_q;
        oq = far.tx_q;
      end else begin
        tq = far.tx_q;
        oq = far.rx_q;
      end
      `CHK(oq.size(), 0)
      `CHK(tq[3] - tq[2], 16)
    end
    finish_test();
  end
endmodule
`default_nettype wire
